// ===== hw/mmx_channel_select.sv
/*
 Channel-select logic for the 24-input analog monitor multiplexer: decodes enable and
 channel code into pull-down, high-impedance or one-of-24 source selection, divider
 choice and buffer enable.
 Assumes enable and code come from the device's serial-port registers, synchronous to clk_i.
*/
// Summary of operation
// - With the enable bit low the mux is off and the output is pulled to ground whatever the code.
// - With the enable bit high in a system-on state the source named by the five-bit code is routed to the buffer.
// - Enabled with code zero leaves the output floating, neither driven nor pulled low.
// - Codes 1 to 3 pick main input, backup rail and coin cell with dividers 4, 3.5 and 3.
// - Codes 4 to 9 pick buck 1 to 6 feedback, divided by 1.25 at 1.8 V and by 1 otherwise.
// - Code 10 picks buck 7 feedback with a fixed divider of about 2.86.
// - Codes 11 to 14 pick the four linear regulator outputs, each divided by about 3.33.
// - Code 15 picks the die-centre sensor, 16 to 24 the local sensors, 25 to 31 are reserved.
// - The buffered voltage reaches the pin only while the device is in a system-on state.
`timescale 1ns/1ps
module mmx_channel_select #(
	parameter int SETTLE_CYCLES = mmx_pkg::SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control from register bits and power state
	input wire mmx_pkg::mmx_ctrl_t ctrl_i,
	// Analog switch controls
	output mmx_pkg::mmx_sel_t sel_o,
	// Pull-down switch, active high
	output logic pulldown_o,
	// Pin driver enable, low while the buffer drives the pin
	output logic pin_oe_n_o,
	// Driven output settled after the last change; stays low while the pin is not driven
	output logic settled_o
);
	import mmx_pkg::*;

	typedef struct packed {
		mmx_sel_t sel;
		logic [CODE_W:0] last_req;
	} mmx_state_t;

	mmx_state_t state;
	mmx_state_t next_state;
	logic change;
	logic req_enable;
	logic [CODE_W-1:0] req_code;
	mmx_out_t req_mode;
	mmx_div_t req_divider;

	// A count the timer register cannot hold would silently shorten the settle window
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W))
	begin : g_settle_range
		$error("mmx_channel_select: SETTLE_CYCLES out of range");
	end

	// The one-hot vector needs exactly one switch per non-reserved nonzero code
	if (NUM_SRC != int'(CODE_TEMP_LAST))
	begin : g_source_count
		$error("mmx_channel_select: NUM_SRC does not match the last channel code");
	end

	// The code field must be able to name every source
	if ((1 << CODE_W) <= NUM_SRC)
	begin : g_code_width
		$error("mmx_channel_select: CODE_W too narrow for NUM_SRC");
	end

	// Codes above the last sensor select nothing
	function automatic logic is_reserved(input logic [CODE_W-1:0] code);
		return code > CODE_TEMP_LAST;
	endfunction

	// Codes that name a real source
	function automatic logic is_source(input logic [CODE_W-1:0] code);
		return code != CODE_HIZ && !is_reserved(code);
	endfunction

	// One switch per source; a compare per bit keeps codes 0 and 25 to 31 off the vector
	function automatic logic [NUM_SRC-1:0] onehot(input logic [CODE_W-1:0] code);
		logic [NUM_SRC-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (is_source(code) && code == CODE_W'(i + 1))
			begin
				v[i] = 1'b1;
			end
		end
		return v;
	endfunction

	// Pin mode for one request; enable governs the pull-down even outside system-on
	function automatic mmx_out_t mode_for(input logic enable, input logic [CODE_W-1:0] code,
		input logic system_on);
		mmx_out_t m;
		if (!enable)
		begin
			m = MMX_OUT_PULLDOWN;
		end
		else if (code == CODE_HIZ)
		begin
			m = MMX_OUT_HIZ;
		end
		else if (is_reserved(code))
		begin
			// Reserved codes float the pin so no internal node is disturbed
			m = MMX_OUT_HIZ;
		end
		else if (!system_on)
		begin
			// Outside system-on the buffer stays off and the pin floats
			m = MMX_OUT_HIZ;
		end
		else
		begin
			m = MMX_OUT_DRIVE;
		end
		return m;
	endfunction

	// Divider for a driven source; off, floating and reserved settings need none
	function automatic mmx_div_t divider_for(input logic [CODE_W-1:0] code, input logic at_1v8);
		mmx_div_t d;
		unique case (code) inside
			CODE_MAIN_IN:
			begin
				d = MMX_DIV_4;
			end
			CODE_BACKUP:
			begin
				d = MMX_DIV_3P5;
			end
			CODE_COIN:
			begin
				d = MMX_DIV_3;
			end
			[CODE_BUCK1:CODE_BUCK6]:
			begin
				// Only the 1.8 V setting needs scaling into the buffer range
				if (at_1v8)
				begin
					d = MMX_DIV_BUCK;
				end
				else
				begin
					d = MMX_DIV_NONE;
				end
			end
			CODE_BUCK7:
			begin
				d = MMX_DIV_2P86;
			end
			[CODE_REG1:CODE_REG4]:
			begin
				d = MMX_DIV_3P33;
			end
			[CODE_TEMP_DIE:CODE_TEMP_LAST]:
			begin
				// Sensors feed the buffer unscaled
				d = MMX_DIV_NONE;
			end
			default:
			begin
				d = MMX_DIV_NONE;
			end
		endcase
		return d;
	endfunction

	assign req_enable = ctrl_i.monitor_mux_enable;
	assign req_code = ctrl_i.monitor_channel_code;
	assign req_mode = mode_for(req_enable, req_code, ctrl_i.system_on);
	assign req_divider = divider_for(req_code, ctrl_i.buck_at_1v8);

	always_comb
	begin
		next_state = state;
		next_state.last_req = {req_enable, req_code};
		next_state.sel.out_mode = req_mode;
		next_state.sel.reserved_code = req_enable && is_reserved(req_code);
		if (req_mode == MMX_OUT_DRIVE)
		begin
			next_state.sel.buffer_on = 1'b1;
			next_state.sel.source_onehot = onehot(req_code);
			next_state.sel.divider = req_divider;
		end
		else
		begin
			// Every source switch opens, so nothing reaches the floating or grounded pin
			next_state.sel.buffer_on = 1'b0;
			next_state.sel.source_onehot = '0;
			next_state.sel.divider = MMX_DIV_NONE;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= '0;
		end
		else
			state <= next_state;
	end

	// Any change of enable or code restarts the settle window
	assign change = next_state.last_req != state.last_req;

	mmx_settle_timer #(
		.CYCLES(SETTLE_CYCLES)
	) u_settle (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.restart_i(change),
		.active_i(next_state.sel.buffer_on),
		.settled_o(settled_o)
	);

	// Pin controls decode the registered mode, so they switch in step with sel_o
	assign sel_o = state.sel;
	assign pulldown_o = state.sel.out_mode == MMX_OUT_PULLDOWN;
	assign pin_oe_n_o = state.sel.out_mode != MMX_OUT_DRIVE;
endmodule // mmx_channel_select

// ===== hw/mmx_pkg.sv
/*
 Package for the monitor multiplexer channel-select logic: channel codes, switch fields,
 settling time and the control/selection structs.
 Assumes a single 125 MHz clock.
*/
package mmx_pkg;
	localparam int CODE_W = 5;
	localparam int NUM_SRC = 24;
	localparam int CLK_MHZ = 125;
	// Settling time after enable or channel change, in microseconds
	localparam int SETTLE_US = 50;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int CNT_W = 14;

	localparam logic [4:0] CODE_HIZ = 5'h00;
	localparam logic [4:0] CODE_MAIN_IN = 5'h01;
	localparam logic [4:0] CODE_BACKUP = 5'h02;
	localparam logic [4:0] CODE_COIN = 5'h03;
	localparam logic [4:0] CODE_BUCK1 = 5'h04;
	localparam logic [4:0] CODE_BUCK6 = 5'h09;
	localparam logic [4:0] CODE_BUCK7 = 5'h0a;
	localparam logic [4:0] CODE_REG1 = 5'h0b;
	localparam logic [4:0] CODE_REG4 = 5'h0e;
	localparam logic [4:0] CODE_TEMP_DIE = 5'h0f;
	localparam logic [4:0] CODE_TEMP_LAST = 5'h18;

	// Divider selections for the conditioning stage
	typedef enum logic [2:0] {
		MMX_DIV_NONE = 3'b000,
		MMX_DIV_4 = 3'b001,
		MMX_DIV_3P5 = 3'b010,
		MMX_DIV_3 = 3'b011,
		MMX_DIV_BUCK = 3'b100,
		MMX_DIV_2P86 = 3'b101,
		MMX_DIV_3P33 = 3'b110
	} mmx_div_t;

	typedef enum logic [1:0] {
		MMX_OUT_PULLDOWN = 2'b00,
		MMX_OUT_HIZ = 2'b01,
		MMX_OUT_DRIVE = 2'b10
	} mmx_out_t;

	typedef struct packed {
		logic monitor_mux_enable;
		logic [CODE_W-1:0] monitor_channel_code;
		logic system_on;
		logic buck_at_1v8;
	} mmx_ctrl_t;

	typedef struct packed {
		mmx_out_t out_mode;
		logic [NUM_SRC-1:0] source_onehot;
		mmx_div_t divider;
		logic buffer_on;
		logic reserved_code;
	} mmx_sel_t;
endpackage

// ===== hw/mmx_settle_timer.sv
/*
 Settle timer for the monitor multiplexer: restarts on every enable or channel-code change and
 reports when the output may be trusted.
 Assumes restart is a one-cycle pulse in the clk_i domain.
*/
`timescale 1ns/1ps
module mmx_settle_timer #(
	parameter int CYCLES = mmx_pkg::SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic restart_i,
	input wire logic active_i,
	// Status
	output logic settled_o
);
	import mmx_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic settled;
	} mmx_tmr_state_t;

	mmx_tmr_state_t state;
	mmx_tmr_state_t next_state;

	if (CYCLES < 1 || CYCLES >= (1 << CNT_W))
	begin : g_cycles_range
		$error("mmx_settle_timer: CYCLES out of range");
	end

	always_comb
	begin
		next_state = state;
		if (!active_i || restart_i)
		begin
			next_state.count = CNT_W'(CYCLES);
			next_state.settled = 1'b0;
		end
		else if (state.count != '0)
			next_state.count = state.count - CNT_W'(1);
		else
			next_state.settled = 1'b1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign settled_o = state.settled;
endmodule // mmx_settle_timer

// ===== test/mmx_host_model.sv
/* Host model reading the monitor pin.
 Assumes the pin level is formed from the block's pin controls. */
`timescale 1ns/1ps
module mmx_host_model (
	// Clock
	input wire logic clk_i,
	// Pin controls from the block
	input wire logic pulldown_i,
	input wire logic pin_oe_n_i,
	input wire logic settled_i,
	// Pin level and trusted readings
	output logic pin_o,
	output int reads_o
);
	// A floating pin toggles, so a guessed level never passes for a pull-down
	logic flip = 1'b0;
	int reads = 0;
	assign pin_o = !pin_oe_n_i ? 1'b1 : (pulldown_i ? 1'b0 : flip);
	assign reads_o = reads;
	always @(posedge clk_i)
	begin
		flip <= !flip;
		// Readings only count once the settle window has passed
		if (settled_i && !pin_oe_n_i)
			reads <= reads + 1;
	end
endmodule // mmx_host_model

// ===== test/mmx_props.sv
/* Port checker for the monitor mux channel select.
 Assumes SETTLE_CYCLES of 8 or more. */
`timescale 1ns/1ps
module mmx_props
	import mmx_pkg::*;
#(
	parameter int SETTLE_CYCLES = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Watched ports
	input wire mmx_pkg::mmx_ctrl_t ctrl_i,
	input wire mmx_pkg::mmx_sel_t sel_o,
	input wire logic pulldown_o,
	input wire logic pin_oe_n_o,
	input wire logic settled_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	if (SETTLE_CYCLES < 8)
	begin : g_settle_min
		$error("mmx_props: SETTLE_CYCLES below the settle-low window");
	end
	wire logic en = ctrl_i.monitor_mux_enable;
	wire logic [4:0] cd = ctrl_i.monitor_channel_code;
	wire logic dr = en && ctrl_i.system_on && cd != 5'h00 && cd < 5'h19;
	chk_off_pulls: assert property (!en |=> pulldown_o && pin_oe_n_o)
		else $error("not pulled down");
	chk_src_routed: assert property (dr |=> sel_o.source_onehot == 24'h1 << ($past(cd) - 5'h1))
		else $error("wrong source");
	chk_zero_hiz: assert property (en && cd == 5'h00 |=> !pulldown_o && pin_oe_n_o)
		else $error("code zero not floating");
	chk_buck_div: assert property (dr && cd inside {[5'h04:5'h09]} |=> sel_o.divider ==
		($past(ctrl_i.buck_at_1v8) ? MMX_DIV_BUCK : MMX_DIV_NONE))
		else $error("buck divider");
	chk_ldo_div: assert property (dr && cd inside {[5'h0b:5'h0e]} |=> sel_o.divider == MMX_DIV_3P33)
		else $error("regulator divider");
	chk_resv_code: assert property (en && cd > 5'h18 |=> sel_o.reserved_code && pin_oe_n_o)
		else $error("reserved code driven");
	chk_sys_off: assert property (!ctrl_i.system_on |=> pin_oe_n_o)
		else $error("driven outside system-on");
	chk_settle_low: assert property ($changed({en, cd}) |=> (!settled_o) [*8])
		else $error("settled too early");
	chk_supply_div: assert property (dr && cd inside {[5'h01:5'h03]} |=> sel_o.divider ==
		($past(cd) == 5'h01 ? MMX_DIV_4 : $past(cd) == 5'h02 ? MMX_DIV_3P5 : MMX_DIV_3))
		else $error("supply divider");
	chk_buck7_div: assert property (dr && cd == 5'h0a |=> sel_o.divider == MMX_DIV_2P86)
		else $error("buck 7 divider");
	chk_settle_drv: assert property (settled_o |-> !pin_oe_n_o)
		else $error("settled while not driving");
	cover property (dr);
	cover property (en && cd > 5'h18);
	cover property ($rose(settled_o));
endmodule // mmx_props
bind mmx_channel_select mmx_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (.clk_i, .arst_n_i,
	.ctrl_i, .sel_o, .pulldown_o, .pin_oe_n_o, .settled_o);

// ===== test/tb_mmx_channel_select.sv
/* Self-checking bench for the monitor mux channel select.
 Assumes a shortened settle count of 10 cycles. */
`timescale 1ns/1ps
module tb_mmx_channel_select;
	import mmx_pkg::*;
	localparam int SC = 10;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	mmx_ctrl_t ctrl_i = '0;
	mmx_sel_t sel_o;
	logic pulldown_o, pin_oe_n_o, settled_o, pin;
	int reads, errors = 0, checks = 0;
	mmx_channel_select #(.SETTLE_CYCLES(SC)) dut (.clk_i, .arst_n_i, .ctrl_i, .sel_o,
		.pulldown_o, .pin_oe_n_o, .settled_o);
	mmx_host_model host (.clk_i, .pulldown_i(pulldown_o), .pin_oe_n_i(pin_oe_n_o),
		.settled_i(settled_o), .pin_o(pin), .reads_o(reads));
	initial forever #4 clk_i = !clk_i;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic step(input logic e, input logic [4:0] c, input logic s, input logic b);
		logic d;
		int dv;
		@(posedge clk_i);
		ctrl_i <= '{e, c, s, b};
		@(posedge clk_i);
		#1;
		d = e && s && c != 0 && c < 25;
		dv = !d ? 0 : c < 4 ? c : c < 10 ? (b ? 4 : 0) : c == 10 ? 5 : c < 15 ? 6 : 0;
		cmp(pulldown_o, !e);
		cmp(pin_oe_n_o, !d);
		cmp(sel_o.out_mode, !e ? 0 : d ? 2 : 1);
		cmp(sel_o.source_onehot, d ? 24'h1 << (c - 1) : 0);
		cmp(sel_o.buffer_on, d);
		cmp(sel_o.divider, dv);
		cmp(sel_o.reserved_code, e && c > 24);
		if (!e) cmp(pin, 0);
	endtask
	task automatic settle();
		int n = 0;
		while (settled_o !== 1'b1 && n < SC + 20)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		cmp(n, SC + 1);
		if (n >= SC + 20) conclude();
	endtask
	initial
	begin
		logic re;
		logic [4:0] rc;
		void'($urandom(32'h65510af6));
		@(posedge clk_i);
		#1 cmp({pulldown_o, pin_oe_n_o, settled_o}, 3'h6);
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int c = 0; c < 32; c++) step(1, c[4:0], 1, c[0]);
		$display("Sweep done");
		step(1, 5'h04, 1, 1);
		settle();
		@(posedge clk_i);
		#1 cmp(reads > 0, 1);
		$display("Settle done");
		for (int c = 0; c < 8; c++) step(c[0], 5'h0b, c[1], 1);
		$display("Power-state done");
		repeat (60)
		begin
			re = 1'($urandom);
			rc = 5'($urandom);
			if (re && rc > 5'h18)
				rc = rc - 5'h19;
			step(re, rc, 1'($urandom), 1'($urandom));
		end
		$display("Random done");
		conclude();
	end
endmodule // tb_mmx_channel_select
